// >>> logic/switch_node_ctrl.sv
// control, routing and link setup logic of one switch node
// What this block does
// - 16-bit read-write reference divider in low half, reset three, upper bits read zero.
// - upper fourteen user code bits show the value held in one-time storage.
// - low eighteen user code bits show a fixed, revisable identification code.
// - eight 4-bit directions, reset zero, for low-byte mismatches, dimension d at 4d+3:4d.
// - eight more 4-bit directions, reset zero, for high-byte dimensions 8 to 15.
// - route by the highest bit where destination and local identifier differ.
// - debug source bits 1 and 0 name the processor of the latest halt event.
// - each link reports a read-only 2-bit source target kind at 25:24.
// - each link reports its current destination link number at 23:16.
// - each external link has a read-write 4-bit direction, reset zero.
// - each link and processor link has a read-write 2-bit network number.
// - per link flags: junk packet bit 2, destination busy bit 1, source busy bit 0.
// - processor link status from 0x40, same fields without direction, 15:6 read zero.
// - setup bit 31 enables the external link and steers the shared pin mux.
// - setup bit 30 selects two-wire at zero, its reset value, five-wire at one.
// - bit 27 flags receive overflow or an illegally encoded token.
// - bits 26 and 25 show credit granted and credit held; no send without credit.
// - writing bit 24 clears local credit and sends a credit start token.
// - writing bit 23 resets the receiver so the next symbol starts a token.
// - at least value plus one idle clocks between symbols of one token.
// - at least value plus one idle clocks between tokens, value reset zero.
// - 16-bit local node identifier taken from an input port, not a register, used for routing.
module switch_node_ctrl
	import switch_node_pkg::*;
#(
	parameter int          NUM_LINKS  = 8,
	parameter int          NUM_CORE   = 8,
	parameter logic [31:0] SCAN_ID    = 32'h1234_5001, // arbitrary value
	parameter logic [17:0] METAL_ID   = 18'h0_0A5C     // arbitrary value
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 cfg_req,
	input  wire logic                 cfg_write,
	input  wire logic [7:0]           cfg_addr,
	input  wire logic [31:0]          cfg_wdata,
	output logic                      cfg_ack,
	output logic [31:0]               cfg_rdata,
	input  wire logic [15:0]          local_node_id,
	input  wire logic [13:0]          otp_user_code,
	input  wire logic                 halt_event,
	input  wire logic [1:0]           halt_source,
	input  wire route_status_s        link_status  [NUM_LINKS],
	input  wire route_status_s        core_status  [NUM_CORE],
	input  wire route_req_s           route_req,
	output route_ans_s                route_ans,
	output logic [15:0]               ref_clk_div,
	output logic [3:0]                link_dir     [NUM_LINKS],
	output logic [1:0]                link_net     [NUM_LINKS],
	output logic [1:0]                core_net     [NUM_CORE],
	output link_mode_s                link_mode    [NUM_LINKS],
	input  wire logic [NUM_LINKS-1:0] rx_fault,
	input  wire logic [NUM_LINKS-1:0] credit_in,
	input  wire logic [NUM_LINKS-1:0] credit_grant,
	output logic [NUM_LINKS-1:0]      credit_start_send,
	output logic [NUM_LINKS-1:0]      rx_restart,
	input  wire logic [NUM_LINKS-1:0] tx_sym_valid,
	input  wire logic [NUM_LINKS-1:0] tx_sym_last,
	output logic [NUM_LINKS-1:0]      tx_sym_ready
);

	logic [15:0] ref_div_ff;
	logic [31:0] dirs_lo_ff;
	logic [31:0] dirs_hi_ff;
	logic [1:0]  spare_a_ff;
	logic [1:0]  spare_b_ff;
	logic [1:0]  debug_src_ff;
	logic        debug_spare_ff;
	logic [3:0]  dir_ff      [NUM_LINKS];
	logic [1:0]  net_ff      [NUM_LINKS];
	logic [1:0]  core_net_ff [NUM_CORE];
	logic        enable_ff   [NUM_LINKS];
	logic        wire_ff     [NUM_LINKS];
	logic        err_ff      [NUM_LINKS];
	logic        grant_ff    [NUM_LINKS];
	logic        credit_ff   [NUM_LINKS];
	logic [10:0] sym_gap_ff  [NUM_LINKS];
	logic [10:0] tok_gap_ff  [NUM_LINKS];
	logic [10:0] gap_cnt_ff  [NUM_LINKS];
	tx_pace_e    pace_ff     [NUM_LINKS];
	logic [NUM_LINKS-1:0] credit_start_token_ff;
	logic [NUM_LINKS-1:0] rxrst_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	route_ans_s  ans_ff;
	logic [31:0] nxt_rdata;

	logic        wr_en;
	logic [2:0]  sel;
	logic        hit_link_stat;
	logic        hit_core_stat;
	logic        hit_link_setup;

	assign wr_en          = cfg_req && cfg_write;
	assign sel            = cfg_addr[2:0];
	assign hit_link_stat  = cfg_addr[7:3] == REG_LINK_STAT_BASE[7:3] && 32'(sel) < NUM_LINKS;
	assign hit_core_stat  = cfg_addr[7:3] == REG_CORE_STAT_BASE[7:3] && 32'(sel) < NUM_CORE;
	assign hit_link_setup = cfg_addr[7:3] == REG_LINK_SETUP_BASE[7:3] && 32'(sel) < NUM_LINKS;

	// highest differing bit of two node identifiers
	function automatic logic [3:0] top_mismatch(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] diff;
		logic [3:0]  pos;
		diff = a ^ b;
		pos  = 4'h0;
		for (int k = 0; k < 16; k++) begin
			if (diff[k]) begin
				pos = 4'(k);
			end
		end
		return pos;
	endfunction

	// status word common to external and processor links
	function automatic logic [31:0] status_word(input route_status_s s, input logic [1:0] net);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[STAT_KIND_LSB +: 2] = s.kind;
		w[STAT_DEST_LSB +: 8] = s.dest_link;
		w[STAT_NET_LSB +: 2]  = net;
		w[STAT_JUNK_BIT]      = s.junk;
		w[STAT_DBUSY_BIT]     = s.dest_busy;
		w[STAT_SBUSY_BIT]     = s.src_busy;
		return w;
	endfunction

	// global registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_div_ff <= REF_DIV_RST;
			dirs_lo_ff <= DIRS_RST;
			dirs_hi_ff <= DIRS_RST;
			spare_a_ff <= 2'h0;
			spare_b_ff <= 2'h0;
		end else if (wr_en) begin
			case (cfg_addr)
				REG_REF_CLK: ref_div_ff <= cfg_wdata[15:0];
				REG_DIRS_LO: dirs_lo_ff <= cfg_wdata;
				REG_DIRS_HI: dirs_hi_ff <= cfg_wdata;
				REG_SPARE_A: spare_a_ff <= cfg_wdata[1:0];
				REG_SPARE_B: spare_b_ff <= cfg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// debug source: a new halt event wins over a software write
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			debug_src_ff   <= 2'h0;
			debug_spare_ff <= 1'b0;
		end else begin
			if (halt_event) begin
				debug_src_ff <= halt_source;
			end else if (wr_en && cfg_addr == REG_DEBUG_SRC) begin
				debug_src_ff <= cfg_wdata[1:0];
			end
			if (wr_en && cfg_addr == REG_DEBUG_SRC) begin
				debug_spare_ff <= cfg_wdata[DEBUG_SPARE_BIT];
			end
		end
	end

	// per-link direction and network
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_LINKS; i++) begin
				dir_ff[i] <= 4'h0;
				net_ff[i] <= 2'h0;
			end
			for (int i = 0; i < NUM_CORE; i++) begin
				core_net_ff[i] <= 2'h0;
			end
		end else begin
			for (int i = 0; i < NUM_LINKS; i++) begin
				if (wr_en && hit_link_stat && 32'(sel) == i) begin
					dir_ff[i] <= cfg_wdata[STAT_DIR_LSB +: 4];
					net_ff[i] <= cfg_wdata[STAT_NET_LSB +: 2];
				end
			end
			for (int i = 0; i < NUM_CORE; i++) begin
				if (wr_en && hit_core_stat && 32'(sel) == i) begin
					core_net_ff[i] <= cfg_wdata[STAT_NET_LSB +: 2];
				end
			end
		end
	end

	// link setup, credit and error state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_LINKS; i++) begin
				enable_ff[i]  <= 1'b0;
				wire_ff[i]    <= 1'b0;
				err_ff[i]     <= 1'b0;
				grant_ff[i]   <= 1'b0;
				credit_ff[i]  <= 1'b0;
				sym_gap_ff[i] <= GAP_RST;
				tok_gap_ff[i] <= GAP_RST;
			end
			credit_start_token_ff <= '0;
			rxrst_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_LINKS; i++) begin
				credit_start_token_ff[i] <= 1'b0;
				rxrst_ff[i] <= 1'b0;
				if (wr_en && hit_link_setup && 32'(sel) == i) begin
					enable_ff[i]  <= cfg_wdata[SETUP_ENABLE_BIT];
					wire_ff[i]    <= cfg_wdata[SETUP_WIRE_BIT];
					sym_gap_ff[i] <= cfg_wdata[SETUP_SYM_LSB +: 11];
					tok_gap_ff[i] <= cfg_wdata[SETUP_TOK_LSB +: 11];
					credit_start_token_ff[i]   <= cfg_wdata[SETUP_CREDIT_START_TOKEN_BIT];
					rxrst_ff[i]   <= cfg_wdata[SETUP_RXRST_BIT];
				end
				// incoming credit beats a simultaneous clear
				if (credit_in[i]) begin
					credit_ff[i] <= 1'b1;
				end else if (wr_en && hit_link_setup && 32'(sel) == i && cfg_wdata[SETUP_CREDIT_START_TOKEN_BIT]) begin
					credit_ff[i] <= 1'b0;
				end
				if (credit_grant[i]) begin
					grant_ff[i] <= 1'b1;
				end else if (wr_en && hit_link_setup && 32'(sel) == i && cfg_wdata[SETUP_RXRST_BIT]) begin
					grant_ff[i] <= 1'b0;
				end
				if (rx_fault[i]) begin
					err_ff[i] <= 1'b1;
				end else if (wr_en && hit_link_setup && 32'(sel) == i && cfg_wdata[SETUP_RXRST_BIT]) begin
					err_ff[i] <= 1'b0;
				end
			end
		end
	end

	// transmit pacing: gap state holds value+1 idle clocks
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_LINKS; i++) begin
				pace_ff[i]    <= TX_READY;
				gap_cnt_ff[i] <= GAP_RST;
			end
		end else begin
			for (int i = 0; i < NUM_LINKS; i++) begin
				case (pace_ff[i])
					TX_READY: begin
						if (tx_sym_valid[i] && tx_sym_ready[i]) begin
							if (tx_sym_last[i]) begin
								pace_ff[i]    <= TX_TOK_GAP;
								gap_cnt_ff[i] <= tok_gap_ff[i];
							end else begin
								pace_ff[i]    <= TX_SYM_GAP;
								gap_cnt_ff[i] <= sym_gap_ff[i];
							end
						end
					end
					TX_SYM_GAP, TX_TOK_GAP: begin
						if (gap_cnt_ff[i] == 11'h000) begin
							pace_ff[i] <= TX_READY;
						end else begin
							gap_cnt_ff[i] <= gap_cnt_ff[i] - 11'h001;
						end
					end
					default: pace_ff[i] <= TX_READY;
				endcase
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_LINKS; i++) begin
			// no symbol leaves without credit
			tx_sym_ready[i] = pace_ff[i] == TX_READY && enable_ff[i] && credit_ff[i];
		end
	end

	// routing answer, one cycle after the request
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ans_ff <= '0;
		end else begin
			logic [3:0] dim;
			dim = top_mismatch(route_req.dest_id, local_node_id);
			ans_ff.valid     <= route_req.valid;
			ans_ff.dim       <= dim;
			ans_ff.local_hit <= route_req.dest_id == local_node_id;
			if (route_req.dest_id == local_node_id) begin
				ans_ff.dir <= 4'h0;
			end else if (dim[3]) begin
				ans_ff.dir <= dirs_hi_ff[{dim[2:0], 2'b00} +: 4];
			end else begin
				ans_ff.dir <= dirs_lo_ff[{dim[2:0], 2'b00} +: 4];
			end
		end
	end

	// read data decode
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (hit_link_stat) begin
			nxt_rdata = status_word(link_status[sel], net_ff[sel]);
			nxt_rdata[STAT_DIR_LSB +: 4] = dir_ff[sel];
		end else if (hit_core_stat) begin
			nxt_rdata = status_word(core_status[sel], core_net_ff[sel]);
		end else if (hit_link_setup) begin
			nxt_rdata[SETUP_ENABLE_BIT]     = enable_ff[sel];
			nxt_rdata[SETUP_WIRE_BIT]       = wire_ff[sel];
			nxt_rdata[SETUP_ERR_BIT]        = err_ff[sel];
			nxt_rdata[SETUP_GRANT_BIT]      = grant_ff[sel];
			nxt_rdata[SETUP_CREDIT_BIT]     = credit_ff[sel];
			nxt_rdata[SETUP_SYM_LSB +: 11]  = sym_gap_ff[sel];
			nxt_rdata[SETUP_TOK_LSB +: 11]  = tok_gap_ff[sel];
		end else begin
			case (cfg_addr)
				REG_REF_CLK:   nxt_rdata[15:0] = ref_div_ff;
				REG_SCAN_ID:   nxt_rdata = SCAN_ID;
				REG_USER_CODE: nxt_rdata = {otp_user_code, METAL_ID};
				REG_DIRS_LO:   nxt_rdata = dirs_lo_ff;
				REG_DIRS_HI:   nxt_rdata = dirs_hi_ff;
				REG_SPARE_A:   nxt_rdata[1:0] = spare_a_ff;
				REG_SPARE_B:   nxt_rdata[1:0] = spare_b_ff;
				REG_DEBUG_SRC: begin
					nxt_rdata[1:0]             = debug_src_ff;
					nxt_rdata[DEBUG_SPARE_BIT] = debug_spare_ff;
				end
				default:       nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= cfg_req;
			if (cfg_req && !cfg_write) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	assign cfg_ack           = ack_ff;
	assign cfg_rdata         = rdata_ff;
	assign route_ans         = ans_ff;
	assign ref_clk_div       = ref_div_ff;
	assign credit_start_send = credit_start_token_ff;
	assign rx_restart        = rxrst_ff;

	always_comb begin
		for (int i = 0; i < NUM_LINKS; i++) begin
			link_dir[i]            = dir_ff[i];
			link_net[i]            = net_ff[i];
			link_mode[i].enable    = enable_ff[i];
			link_mode[i].five_wire = wire_ff[i];
		end
		for (int i = 0; i < NUM_CORE; i++) begin
			core_net[i] = core_net_ff[i];
		end
	end

	ref_div_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_en && cfg_addr == REG_REF_CLK |=> ref_clk_div == $past(cfg_wdata[15:0]))
		else $error("reference divider did not take the written value");
	cfg_answer_a: assert property (@(posedge clock) disable iff (!rst_n)
		cfg_req |=> cfg_ack)
		else $error("configuration request not answered in one cycle");
	route_local_a: assert property (@(posedge clock) disable iff (!rst_n)
		route_req.valid && route_req.dest_id == local_node_id |=> route_ans.valid && route_ans.local_hit)
		else $error("matching destination not delivered locally");
	route_dim_a: assert property (@(posedge clock) disable iff (!rst_n)
		route_req.valid && route_req.dest_id[15] != local_node_id[15]
		|=> route_ans.dim == 4'hF && route_ans.dir == $past(dirs_hi_ff[31:28]))
		else $error("route not taken from highest mismatching bit");
	route_low_a: assert property (@(posedge clock) disable iff (!rst_n)
		route_req.valid && (route_req.dest_id ^ local_node_id) == 16'h0001
		|=> route_ans.dir == $past(dirs_lo_ff[3:0]))
		else $error("dimension zero direction wrong");
	credit_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		tx_sym_ready[0] |-> credit_ff[0] && link_mode[0].enable)
		else $error("transmit allowed without credit or enable");
	credit_start_token_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_en && hit_link_setup && sel == 3'h0 && cfg_wdata[SETUP_CREDIT_START_TOKEN_BIT] && !credit_in[0]
		|=> credit_start_send[0] && !credit_ff[0] ##1 !credit_start_send[0])
		else $error("credit start write mishandled");
	err_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
		rx_fault[0] |=> err_ff[0])
		else $error("receive fault not flagged");
	sym_gap_a: assert property (@(posedge clock) disable iff (!rst_n)
		tx_sym_valid[0] && tx_sym_ready[0] && !tx_sym_last[0]
		|=> !tx_sym_ready[0] && gap_cnt_ff[0] == $past(sym_gap_ff[0]))
		else $error("symbol gap not started");
	debug_src_a: assert property (@(posedge clock) disable iff (!rst_n)
		halt_event |=> debug_src_ff == $past(halt_source))
		else $error("debug source not recorded");
endmodule

// >>> logic/switch_node_pkg.sv
// constants, register numbers and carrier types of the switch node control block
package switch_node_pkg;

	// register numbers on the configuration port
	localparam logic [7:0] REG_REF_CLK         = 8'h08;
	localparam logic [7:0] REG_SCAN_ID         = 8'h09;
	localparam logic [7:0] REG_USER_CODE       = 8'h0A;
	localparam logic [7:0] REG_DIRS_LO         = 8'h0C;
	localparam logic [7:0] REG_DIRS_HI         = 8'h0D;
	localparam logic [7:0] REG_SPARE_A         = 8'h10;
	localparam logic [7:0] REG_SPARE_B         = 8'h11;
	localparam logic [7:0] REG_DEBUG_SRC       = 8'h1F;
	localparam logic [7:0] REG_LINK_STAT_BASE  = 8'h20;
	localparam logic [7:0] REG_CORE_STAT_BASE  = 8'h40;
	localparam logic [7:0] REG_LINK_SETUP_BASE = 8'h80;

	// reset values
	localparam logic [15:0] REF_DIV_RST  = 16'h0003;
	localparam logic [31:0] DIRS_RST     = 32'h0000_0000;
	localparam logic [10:0] GAP_RST      = 11'h000;

	// field positions
	localparam int USER_OTP_LSB     = 18;
	localparam int DEBUG_SPARE_BIT  = 4;
	localparam int STAT_KIND_LSB    = 24;
	localparam int STAT_DEST_LSB    = 16;
	localparam int STAT_DIR_LSB     = 8;
	localparam int STAT_NET_LSB     = 4;
	localparam int STAT_JUNK_BIT    = 2;
	localparam int STAT_DBUSY_BIT   = 1;
	localparam int STAT_SBUSY_BIT   = 0;
	localparam int SETUP_ENABLE_BIT = 31;
	localparam int SETUP_WIRE_BIT   = 30;
	localparam int SETUP_ERR_BIT    = 27;
	localparam int SETUP_GRANT_BIT  = 26;
	localparam int SETUP_CREDIT_BIT = 25;
	localparam int SETUP_CREDIT_START_TOKEN_BIT  = 24;
	localparam int SETUP_RXRST_BIT  = 23;
	localparam int SETUP_SYM_LSB    = 11;
	localparam int SETUP_TOK_LSB    = 0;
	localparam int ID_HALF          = 8;

	typedef enum logic [1:0] {
		KIND_SWITCH_LINK    = 2'h0,
		KIND_PROCESSOR_LINK = 2'h1,
		KIND_CONTROL_TARGET = 2'h2,
		KIND_UNDEFINED      = 2'h3
	} target_kind_e;

	typedef enum logic [2:0] {
		TX_READY    = 3'h1,
		TX_SYM_GAP  = 3'h2,
		TX_TOK_GAP  = 3'h4
	} tx_pace_e;

	typedef struct packed {
		target_kind_e kind;
		logic [7:0]   dest_link;
		logic         junk;
		logic         dest_busy;
		logic         src_busy;
	} route_status_s;

	typedef struct packed {
		logic enable;
		logic five_wire;
	} link_mode_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] dest_id;
	} route_req_s;

	typedef struct packed {
		logic       valid;
		logic       local_hit;
		logic [3:0] dir;
		logic [3:0] dim;
	} route_ans_s;

endpackage

// >>> verification/link_far_end.sv
// far end model of the external links: credit return and a paced token source
module link_far_end #(
	parameter int N = 8
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         send,
	input  wire logic [N-1:0] credit_start_send,
	input  wire logic [N-1:0] tx_sym_ready,
	output logic [N-1:0]      credit_in,
	output logic [N-1:0]      tx_sym_valid,
	output logic [N-1:0]      tx_sym_last,
	output int                sp_sym,
	output int                sp_tok
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [N-1:0] d1   = '0;
	logic [N-1:0] d2   = '0;
	logic [N-1:0] d3   = '0;
	logic [N-1:0] tk   = '0;
	logic         odd  = 1'b0;
	logic         pl   = 1'b0;
	int           cyc  = 0;
	int           last = 0;

	// credit start token answered with credit three cycles later
	always @(posedge clock) begin
		d1 <= rst_n ? credit_start_send : '0;
		tk <= tx_sym_valid & tx_sym_ready;
		d2 <= d1;
		d3 <= d2;
		cyc <= cyc + 1;
		if (!rst_n) begin
			sp_sym <= 0;
			sp_tok <= 0;
		end else if (tx_sym_valid[0] && tx_sym_ready[0]) begin
			if (pl)
				sp_tok <= cyc - last;
			else
				sp_sym <= cyc - last;
			last <= cyc;
			pl <= tx_sym_last[0];
			odd <= ~odd;
		end
	end
	// two-symbol tokens, held until taken
	always @(negedge clock) begin
		credit_in <= d3;
		tx_sym_valid <= rst_n ? ({N{send}} | (tx_sym_valid & ~tk)) : '0;
		tx_sym_last <= {N{odd}};
	end
endmodule

// >>> verification/testbench.sv
// self-checking bench of the switch node control block
module testbench
	import switch_node_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] SCAN  = 32'h0BAD_F00D; // arbitrary value
	localparam logic [17:0] METAL = 18'h2_1357;    // arbitrary value
	logic          clock         = 1'b0;
	logic          rst_n         = 1'b0;
	logic          cfg_req       = 1'b0;
	logic          cfg_write     = 1'b0;
	logic [7:0]    cfg_addr      = 8'h00;
	logic [31:0]   cfg_wdata     = 32'h0;
	logic          cfg_ack;
	logic [31:0]   cfg_rdata;
	logic [15:0]   local_node_id = 16'h0;
	logic [13:0]   otp_user_code = 14'h2A5C;
	logic          halt_event    = 1'b0;
	logic [1:0]    halt_source   = 2'h0;
	route_status_s link_status [8];
	route_status_s core_status [8];
	route_req_s    route_req     = '0;
	route_ans_s    route_ans;
	logic [15:0]   ref_clk_div;
	logic [3:0]    link_dir [8];
	logic [1:0]    link_net [8];
	logic [1:0]    core_net [8];
	link_mode_s    link_mode [8];
	logic [7:0]    rx_fault      = 8'h0;
	logic [7:0]    credit_grant  = 8'h0;
	logic [7:0]    credit_in, css, rx_restart, valid, last, ready;
	logic          send          = 1'b0;
	int            sp_sym, sp_tok, g, t;
	int            errors = 0, checked = 0, n_css = 0, n_rr = 0, seed = 32'hE27C;
	logic [31:0]   q, d, lo, hi, e;
	route_status_s s;

	always #20 clock = ~clock;

	switch_node_ctrl #(.NUM_LINKS(8), .NUM_CORE(8), .SCAN_ID(SCAN), .METAL_ID(METAL)) switch_node_ctrl_inst (
		.clock(clock), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .local_node_id(local_node_id),
		.otp_user_code(otp_user_code), .halt_event(halt_event), .halt_source(halt_source),
		.link_status(link_status), .core_status(core_status), .route_req(route_req), .route_ans(route_ans),
		.ref_clk_div(ref_clk_div), .link_dir(link_dir), .link_net(link_net), .core_net(core_net),
		.link_mode(link_mode), .rx_fault(rx_fault), .credit_in(credit_in), .credit_grant(credit_grant),
		.credit_start_send(css), .rx_restart(rx_restart), .tx_sym_valid(valid), .tx_sym_last(last),
		.tx_sym_ready(ready));

	link_far_end #(.N(8)) link_far_end_inst (
		.clock(clock), .rst_n(rst_n), .send(send), .credit_start_send(css), .tx_sym_ready(ready),
		.credit_in(credit_in), .tx_sym_valid(valid), .tx_sym_last(last), .sp_sym(sp_sym), .sp_tok(sp_tok));

	always @(posedge clock) begin
		if (rst_n && css[0])
			n_css++;
		if (rst_n && rx_restart[0])
			n_rr++;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(negedge clock);
		cfg_req = 1'b1;
		cfg_write = w;
		cfg_addr = a;
		cfg_wdata = wd;
		@(negedge clock);
		cfg_req = 1'b0;
		q = cfg_rdata;
		cmp({31'h0, cfg_ack}, 32'h1, "ack");
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
		cfg(1'b0, a, 32'h0);
		cmp(q, exp, m);
	endtask

	task automatic conclude();
		$display("counts: checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// highest differing bit picks the nibble; a full match is local
	function automatic logic [9:0] exp_route(logic [15:0] dst, logic [15:0] loc, logic [63:0] tab);
		logic [15:0] x;
		x = dst ^ loc;
		exp_route = 10'h300;
		for (int i = 0; i < 16; i++)
			if (x[i])
				exp_route = {2'b10, tab[4 * i +: 4], 4'(i)};
	endfunction

	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		conclude();
	end

	initial begin
		for (int i = 0; i < 8; i++) begin
			link_status[i] = '0;
			core_status[i] = '0;
		end
		repeat (10) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		rd(REG_REF_CLK, 32'h3, "ref div reset");
		rd(REG_DIRS_LO, 32'h0, "dirs lo reset");
		rd(REG_DIRS_HI, 32'h0, "dirs hi reset");
		rd(REG_LINK_SETUP_BASE, 32'h0, "setup reset");
		rd(REG_LINK_STAT_BASE, 32'h0, "status reset");
		cfg(1'b1, REG_REF_CLK, 32'hFFFF_FFFF);
		rd(REG_REF_CLK, 32'h0000_FFFF, "ref div rw");
		cmp({16'h0, ref_clk_div}, 32'h0000_FFFF, "ref div out");
		cfg(1'b1, REG_USER_CODE, 32'hFFFF_FFFF);
		rd(REG_USER_CODE, {otp_user_code, METAL}, "user code");
		rd(REG_SCAN_ID, SCAN, "scan id");
		cfg(1'b1, 8'h28, 32'hFFFF_FFFF);
		rd(8'h28, 32'h0, "unmapped");
		rd(8'h88, 32'h0, "unmapped");
		cfg(1'b1, REG_SPARE_A, 32'hFFFF_FFFF);
		rd(REG_SPARE_A, 32'h3, "spare a");
		cfg(1'b1, REG_SPARE_B, 32'hFFFF_FFFE);
		rd(REG_SPARE_B, 32'h2, "spare b");
		$display("test registers done");
		for (int i = 0; i < 40; i++) begin
			lo = $random(seed);
			hi = $random(seed);
			cfg(1'b1, REG_DIRS_LO, lo);
			cfg(1'b1, REG_DIRS_HI, hi);
			local_node_id = 16'($random(seed));
			d = $random(seed);
			case (i % 3)
				0: d[15:0] = local_node_id;
				1: d[15:0] = local_node_id ^ (16'h1 << (i % 16));
				default: ;
			endcase
			@(negedge clock);
			route_req = {1'b1, d[15:0]};
			@(negedge clock);
			route_req = '0;
			e = {22'h0, exp_route(d[15:0], local_node_id, {hi, lo})};
			q = (d[15:0] == local_node_id) ? 32'h3F0 : 32'h3FF;
			cmp({22'h0, route_ans} & q, e & q, "route");
		end
		rd(REG_DIRS_HI, hi, "dirs hi rw");
		$display("test routing done");
		for (int k = 1; k < 3; k++) begin
			@(negedge clock);
			halt_event = 1'b1;
			halt_source = 2'(k);
			@(negedge clock);
			halt_event = 1'b0;
			cfg(1'b0, REG_DEBUG_SRC, 32'h0);
			cmp(q & 32'h3, 32'(k), "debug source");
		end
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			s = route_status_s'(13'($random(seed)));
			link_status[i] = s;
			core_status[i] = s;
			cfg(1'b1, REG_LINK_STAT_BASE + 8'(i), d);
			cfg(1'b1, REG_CORE_STAT_BASE + 8'(i), d);
			e = {6'h0, s.kind, s.dest_link, 13'h0, s.junk, s.dest_busy, s.src_busy};
			rd(REG_LINK_STAT_BASE + 8'(i), e | (d & 32'h0F30), "link status");
			rd(REG_CORE_STAT_BASE + 8'(i), e | (d & 32'h0030), "core status");
			cmp({26'h0, link_dir[i], link_net[i]}, {26'h0, d[11:8], d[5:4]}, "dir net");
			cmp({30'h0, core_net[i]}, {30'h0, d[5:4]}, "core net");
		end
		for (int i = 0; i < 8; i++) begin
			d = $random(seed) & 32'hFE7F_FFFF;
			cfg(1'b1, REG_LINK_SETUP_BASE + 8'(i), d);
			rd(REG_LINK_SETUP_BASE + 8'(i), d & 32'hC03F_FFFF, "setup rw");
			cmp({30'h0, link_mode[i]}, {30'h0, d[31:30]}, "link mode");
		end
		$display("test status done");
		g = $random(seed) & 7;
		t = $random(seed) & 7;
		d = {1'b1, 9'h0, 11'(g), 11'(t)};
		@(negedge clock);
		rx_fault[0] = 1'b1;
		credit_grant[0] = 1'b1;
		@(negedge clock);
		rx_fault = 8'h0;
		credit_grant = 8'h0;
		cfg(1'b1, REG_LINK_SETUP_BASE, d);
		rd(REG_LINK_SETUP_BASE, d | 32'h0C00_0000, "fault grant");
		cfg(1'b1, REG_LINK_SETUP_BASE, d | 32'h0080_0000);
		rd(REG_LINK_SETUP_BASE, d, "rx reset");
		cmp(32'(n_rr), 32'h1, "rx restart");
		cfg(1'b1, REG_LINK_SETUP_BASE, d | 32'h0100_0000);
		repeat (8) @(negedge clock);
		rd(REG_LINK_SETUP_BASE, d | 32'h0200_0000, "credit held");
		cfg(1'b1, REG_LINK_SETUP_BASE, d | 32'h0100_0000);
		rd(REG_LINK_SETUP_BASE, d, "credit cleared");
		cmp(32'(n_css), 32'h2, "start token");
		repeat (8) @(negedge clock);
		send <= 1'b1;
		repeat (80) @(negedge clock);
		send <= 1'b0;
		cmp(32'(sp_sym), 32'(g + 2), "symbol spacing");
		cmp(32'(sp_tok), 32'(t + 2), "token spacing");
		$display("test link done");
		conclude();
	end
endmodule
